//--- logic/lfv_ctrl.sv
// control and fault logic of the led foldback, dimming and valley controller
`timescale 1ns/1ps
`include "lfv_params.svh"

// Behaviour
// - thermal level below start lowers reference proportionally
// - standard variant floor is half current
// - steep variant floor is quarter current
// - auto-recovery overtemp: stop, 4 s, release level
// - latching overtemp holds off until supply reset
// - no gate pulses for 180 us after turn-on
// - thermal overvoltage shuts down, waits 4 s
// - light level scales current between enable, full
// - light level below enable blocks gate pulses
// - pwm high below full scale also lowers reference
// - dimming and foldback factors multiply
// - weak pull-up on light level input
// - supply overvoltage stops, 4 s, needs turn-on level
// - stay in valley until line or current moves
// - valley from line, thermal and light levels
// - full current: first valley low, second high line
// - line range hysteresis 2.4 V up, 2.3 V down
// - band edges down 75/50/30/15/6, up 78/53/33/20/8
// - auto-recovery: stop, 4 s, then start-up sequence
module lfv_ctrl #(
  parameter bit STEEP_FOLDBACK = 1'b0,
  parameter bit LATCH_OVERTEMP = 1'b0,
  parameter int HOLD_CYCLES    = `LFV_HOLD_CYCLES,
  parameter int FAULT_CYCLES   = `LFV_FAULT_CYCLES
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic [`LFV_LEVEL_W-1:0] thermalSenseInput,
  input  wire logic [`LFV_LEVEL_W-1:0] lightLevelInput,
  input  wire logic [`LFV_LEVEL_W-1:0] lineSenseInput,
  input  wire logic                    supplyOnLevel,
  input  wire logic                    supplyResetLevel,
  input  wire logic                    supplyOvervoltageLevel,
  output logic                         gatePulseOutput,
  output logic [`LFV_LEVEL_W-1:0]      currentReference,
  output logic [3:0]                   valleyNumber,
  output logic                         highLineRange,
  output logic                         faultLatched,
  output logic                         faultTimerRunning,
  output logic                         lightLevelPullupEn
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  // synchronisers, state, counter and outputs in one registered record
  lfv_pkg::lfv_state_s r;
  lfv_pkg::lfv_state_s next_r;

  // counts run from zero, so the last value is one short of the length
  localparam logic [`LFV_CNT_W-1:0] HOLD_LAST  = `LFV_CNT_W'(HOLD_CYCLES - 1);
  localparam logic [`LFV_CNT_W-1:0] FAULT_LAST = `LFV_CNT_W'(FAULT_CYCLES - 1);
  localparam logic [7:0] FLOOR = STEEP_FOLDBACK ? `LFV_FLOOR_QUARTER : `LFV_FLOOR_HALF;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // foldback factor, full code when cool, clamped at the variant floor
  function automatic logic [7:0] foldFactor(input logic [7:0] lvl);
    logic [15:0] span;
    foldFactor = `LFV_FULL_CODE;
    span       = 16'h0000;
    if (lvl <= `LFV_TF_STOP) begin
      foldFactor = FLOOR;
    end else if (lvl < `LFV_TF_START) begin
      span = 16'(lvl - `LFV_TF_STOP) * 16'(`LFV_FULL_CODE - FLOOR);
      foldFactor = FLOOR + 8'(span / 16'(`LFV_TF_START - `LFV_TF_STOP));
    end
  endfunction

  // light factor, zero below enable; above full scale gives full code
  function automatic logic [7:0] dimFactor(input logic [7:0] lvl);
    logic [15:0] span;
    dimFactor = `LFV_FULL_CODE;
    span      = 16'h0000;
    if (lvl < `LFV_DIM_EN) begin
      dimFactor = 8'h00;
    end else if (lvl < `LFV_DIM_FULL) begin
      span = 16'(lvl - `LFV_DIM_EN) * 16'(`LFV_FULL_CODE);
      dimFactor = 8'(span / 16'(`LFV_DIM_FULL - `LFV_DIM_EN));
    end
  endfunction

  // true when factor sits at or above pct percent of full code
  function automatic logic atOrAbove(input logic [7:0] f, input logic [7:0] pct);
    atOrAbove = (16'(f) * 16'd100) >= (16'(pct) * 16'(`LFV_FULL_CODE));
  endfunction

  // edge to the next deeper band; its pair in upEdge sits a little higher
  function automatic logic [7:0] downEdge(input logic [2:0] b);
    case (b)
      3'd0:    downEdge = `LFV_DN_0;
      3'd1:    downEdge = `LFV_DN_1;
      3'd2:    downEdge = `LFV_DN_2;
      3'd3:    downEdge = `LFV_DN_3;
      default: downEdge = `LFV_DN_4;
    endcase
  endfunction

  // edge back to the shallower band; band 0 has none
  function automatic logic [7:0] upEdge(input logic [2:0] b);
    case (b)
      3'd1:    upEdge = `LFV_UP_0;
      3'd2:    upEdge = `LFV_UP_1;
      3'd3:    upEdge = `LFV_UP_2;
      3'd4:    upEdge = `LFV_UP_3;
      default: upEdge = `LFV_UP_4;
    endcase
  endfunction

  // low line repeats the fourth valley where high line splits 5th and 8th
  function automatic logic [3:0] valleyOf(input logic hl, input logic [2:0] b);
    case (b)
      3'd0:    valleyOf = hl ? 4'h2 : 4'h1;
      3'd1:    valleyOf = hl ? 4'h3 : 4'h2;
      3'd2:    valleyOf = hl ? 4'h5 : 4'h4;
      3'd3:    valleyOf = hl ? 4'h8 : 4'h4;
      3'd4:    valleyOf = hl ? 4'hC : 4'hB;
      default: valleyOf = hl ? 4'hF : 4'hD;
    endcase
  endfunction

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  // working values of the next-state logic
  logic [7:0]  tf;
  logic [7:0]  light_level_input;
  logic [15:0] prod;
  logic [7:0]  setPoint;
  logic        supOn;
  logic        supReset;
  logic        supOvp;
  logic        otpTrip;
  logic        sdOvp;

  always_comb begin
    next_r = r;
    // levels are only read after the second stage
    next_r.thermS1 = thermalSenseInput;
    next_r.thermS2 = r.thermS1;
    next_r.lightS1 = lightLevelInput;
    next_r.lightS2 = r.lightS1;
    next_r.lineS1  = lineSenseInput;
    next_r.lineS2  = r.lineS1;
    // the three supply comparators share one two-stage synchroniser
    next_r.supS1   = {supplyOvervoltageLevel, supplyResetLevel, supplyOnLevel};
    next_r.supS2   = r.supS1;

    supOn    = r.supS2[0];
    supReset = r.supS2[1];
    supOvp   = r.supS2[2];
    otpTrip  = r.thermS2 < `LFV_OTP_TRIP;
    sdOvp    = r.thermS2 >= `LFV_SD_OVP;

    tf       = foldFactor(r.thermS2);
    light_level_input      = dimFactor(r.lightS2);
    // product rounded to 8 bits; nominal current reads 0xFE, never 0xFF
    prod     = 16'(tf) * 16'(light_level_input);
    setPoint = prod[15:8] + {7'h00, prod[7]};

    // reference is worked out in every state, so it is ready at restart
    next_r.currentRef  = setPoint;
    next_r.lightPullup = 1'b1;

    // -----------------------------------------------------------------
    // line range and valley
    // -----------------------------------------------------------------
    // line range with hysteresis
    if (!r.highLine && r.lineS2 > `LFV_LINE_HIGH) begin
      next_r.highLine = 1'b1;
    end else if (r.highLine && r.lineS2 < `LFV_LINE_LOW) begin
      next_r.highLine = 1'b0;
    end

    // band moves only past its own edge, one step a cycle; a disabled
    // light level keeps the band so the first pulse after pwm low reuses it
    if (light_level_input != 8'h00) begin
      if (r.band != 3'd0 && atOrAbove(setPoint, upEdge(r.band))) begin
        next_r.band = r.band - 3'd1;
      end else if (r.band != `LFV_LAST_BAND && !atOrAbove(setPoint, downEdge(r.band))) begin
        next_r.band = r.band + 3'd1;
      end
    end
    // valley follows the band in the same cycle, so both change together
    next_r.valley = valleyOf(next_r.highLine, next_r.band);

    // -----------------------------------------------------------------
    // start-up and fault sequencing
    // -----------------------------------------------------------------
    // one counter serves hold-off and fault wait; they never overlap
    next_r.cnt = r.cnt + `LFV_CNT_W'(1);
    case (r.state)
      // off: wait for the supply to reach turn-on
      lfv_pkg::LFV_OFF: begin
        next_r.cnt = '0;
        if (supOn) begin
          next_r.state = lfv_pkg::LFV_HOLD;
        end
      end
      // hold-off: a supply drop starts over from off
      lfv_pkg::LFV_HOLD: begin
        if (!supOn) begin
          next_r.state = lfv_pkg::LFV_OFF;
        end else if (r.cnt >= HOLD_LAST) begin
          next_r.state = lfv_pkg::LFV_RUN;
        end
      end
      // run: latching overtemp outranks the auto-recovery causes
      lfv_pkg::LFV_RUN: begin
        next_r.cnt      = '0;
        next_r.otpCause = 1'b0;
        if (otpTrip && LATCH_OVERTEMP) begin
          next_r.state = lfv_pkg::LFV_LATCH;
        end else if (otpTrip || sdOvp || supOvp) begin
          next_r.state    = lfv_pkg::LFV_WAIT;
          next_r.otpCause = otpTrip;
        end else if (!supOn) begin
          next_r.state = lfv_pkg::LFV_OFF;
        end
      end
      // wait: the timer saturates, so a late supply still restarts
      lfv_pkg::LFV_WAIT: begin
        if (r.cnt >= FAULT_LAST) begin
          next_r.cnt = FAULT_LAST;
          // restart through the hold-off, as after a fresh turn-on
          if (supOn && (!r.otpCause || r.thermS2 > `LFV_OTP_RELEASE)) begin
            next_r.state = lfv_pkg::LFV_HOLD;
            next_r.cnt   = '0;
          end
        end
      end
      // latch: only a collapse of the supply clears it
      lfv_pkg::LFV_LATCH: begin
        next_r.cnt = '0;
        if (supReset) begin
          next_r.state = lfv_pkg::LFV_OFF;
        end
      end
      default: begin
        next_r.state = lfv_pkg::LFV_OFF;
      end
    endcase

    // gate also drops in the cycle a fault is first seen
    next_r.gateEnable = (next_r.state == lfv_pkg::LFV_RUN) && (light_level_input != 8'h00);

    // status flags follow the next state, so they leave a flop with it
    next_r.faultLatch = (next_r.state == lfv_pkg::LFV_LATCH);
    next_r.faultWait  = (next_r.state == lfv_pkg::LFV_WAIT);
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  // synchronous reset; one edge low also flushes the synchronisers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      // supply flags start absent, so the machine leaves reset in off
      r.thermS1     <= `LFV_RST_LEVEL;
      r.thermS2     <= `LFV_RST_LEVEL;
      r.lightS1     <= `LFV_RST_LEVEL;
      r.lightS2     <= `LFV_RST_LEVEL;
      r.lineS1      <= `LFV_RST_LEVEL;
      r.lineS2      <= `LFV_RST_LEVEL;
      r.supS1       <= 3'h0;
      r.supS2       <= 3'h0;
      r.state       <= lfv_pkg::LFV_OFF;
      r.cnt         <= '0;
      r.otpCause    <= 1'b0;
      r.highLine    <= 1'b0;
      r.band        <= `LFV_RST_BAND;
      r.gateEnable  <= 1'b0;
      r.currentRef  <= `LFV_RST_REF;
      r.valley      <= `LFV_RST_VALLEY;
      r.lightPullup <= `LFV_RST_PULLUP;
      r.faultLatch  <= 1'b0;
      r.faultWait   <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign gatePulseOutput    = r.gateEnable;
  assign currentReference   = r.currentRef;
  assign valleyNumber       = r.valley;
  assign highLineRange      = r.highLine;
  assign faultLatched       = r.faultLatch;
  assign faultTimerRunning  = r.faultWait;
  assign lightLevelPullupEn = r.lightPullup;

endmodule // lfv_ctrl

//--- logic/lfv_params.svh
// constants of the led foldback, dimming and valley control block
`ifndef LFV_PARAMS_SVH
`define LFV_PARAMS_SVH

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define LFV_CLK_PERIOD_NS  25
`define LFV_HOLD_US        180
`define LFV_FAULT_MS       4000
`define LFV_HOLD_CYCLES    ((`LFV_HOLD_US * 1000 + `LFV_CLK_PERIOD_NS - 1) / `LFV_CLK_PERIOD_NS)
`define LFV_FAULT_CYCLES   (`LFV_FAULT_MS * (1000000 / `LFV_CLK_PERIOD_NS))
`define LFV_CNT_W          28

// -----------------------------------------------------------------
// sensed level codes, 8 bit, full scale 5 V
// -----------------------------------------------------------------
`define LFV_LEVEL_W        8
`define LFV_FULL_CODE      8'hFF
`define LFV_TF_START       8'h99
`define LFV_TF_STOP        8'h66
`define LFV_OTP_TRIP       8'h4D
`define LFV_OTP_RELEASE    8'h5C
`define LFV_SD_OVP         8'h80
`define LFV_DIM_EN         8'h1A
`define LFV_DIM_FULL       8'hB3
`define LFV_LINE_HIGH      8'h7B
`define LFV_LINE_LOW       8'h75
`define LFV_FLOOR_HALF     8'h80
`define LFV_FLOOR_QUARTER  8'h40

// -----------------------------------------------------------------
// valley bands: percent of nominal current, decreasing / increasing
// -----------------------------------------------------------------
`define LFV_DN_0           8'd75
`define LFV_DN_1           8'd50
`define LFV_DN_2           8'd30
`define LFV_DN_3           8'd15
`define LFV_DN_4           8'd6
`define LFV_UP_0           8'd78
`define LFV_UP_1           8'd53
`define LFV_UP_2           8'd33
`define LFV_UP_3           8'd20
`define LFV_UP_4           8'd8
`define LFV_LAST_BAND      3'd5

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define LFV_RST_LEVEL      8'h00
`define LFV_RST_REF        8'h00
`define LFV_RST_VALLEY     4'h1
`define LFV_RST_BAND       3'h0
`define LFV_RST_PULLUP     1'b1

`endif

//--- logic/lfv_pkg.sv
// types of the led foldback, dimming and valley control block
`include "lfv_params.svh"
package lfv_pkg;

  typedef enum logic [2:0] {
    LFV_OFF   = 3'b000,
    LFV_HOLD  = 3'b001,
    LFV_RUN   = 3'b010,
    LFV_WAIT  = 3'b011,
    LFV_LATCH = 3'b100
  } lfv_state_e;

  typedef logic [`LFV_LEVEL_W-1:0] lfv_level_t;

  typedef struct packed {
    lfv_level_t             thermS1;
    lfv_level_t             thermS2;
    lfv_level_t             lightS1;
    lfv_level_t             lightS2;
    lfv_level_t             lineS1;
    lfv_level_t             lineS2;
    logic [2:0]             supS1;
    logic [2:0]             supS2;
    lfv_state_e             state;
    logic [`LFV_CNT_W-1:0]  cnt;
    logic                   otpCause;
    logic                   highLine;
    logic [2:0]             band;
    logic                   gateEnable;
    lfv_level_t             currentRef;
    logic [3:0]             valley;
    logic                   lightPullup;
    logic                   faultLatch;
    logic                   faultWait;
  } lfv_state_s;

endpackage

//--- test/led_foldback_dimming_valley_ctrl_tb_top.sv
// self-checking bench of the control block
`timescale 1ns/1ps
module led_foldback_dimming_valley_ctrl_tb_top;
  typedef struct packed {
    logic [7:0] th, lt, ln, r1, r2;
    logic [3:0] v1, v2;
    logic       hl, gt;
  } lfv_row_s;
  // of FF means not compared: code FF is out of reach here
  localparam lfv_row_s ROWS [7] = '{
    '{8'h7F, 8'hFF, 8'h40, 8'hFF, 8'hFF, 4'h2, 4'h2, 1'b0, 1'b1},
    '{8'h7F, 8'hFF, 8'h80, 8'hFF, 8'hFF, 4'h3, 4'h3, 1'b1, 1'b1},
    '{8'h60, 8'hFF, 8'h78, 8'h80, 8'h40, 4'h3, 4'h8, 1'b1, 1'b1},
    '{8'h6A, 8'hFF, 8'h78, 8'hFF, 8'hFF, 4'h3, 4'h8, 1'b1, 1'b1},
    '{8'h7F, 8'hFF, 8'h70, 8'hFF, 8'hFF, 4'h2, 4'h2, 1'b0, 1'b1},
    '{8'h6A, 8'hFF, 8'h80, 8'hFF, 8'hFF, 4'h3, 4'h5, 1'b1, 1'b1},
    '{8'h6A, 8'h10, 8'h80, 8'h00, 8'h00, 4'h3, 4'h5, 1'b1, 1'b0}};
  localparam int HC = 8;
  localparam int FC = 20;
  logic       ref_clk = 1'b0;
  logic       rst_n   = 1'b0;
  logic [7:0] th = 8'h7F, ltSet = 8'hFF, ln = 8'h40, lt, cref, cref2, save;
  logic       ltOpen = 1'b0, sOn = 1'b0, sRst = 1'b0, sOv = 1'b0;
  logic       gate, gate2, hl, fl, fl2, ft, pu;
  logic [3:0] vn, vn2;
  int         n_fail = 0;
  int         checks_done = 0;
  initial forever #12.5 ref_clk = ~ref_clk;
  lfv_stage_model stage (.lightSet(ltSet), .lightOpen(ltOpen), .pullupEn(pu), .lightLevel(lt));
  lfv_ctrl #(.HOLD_CYCLES(HC), .FAULT_CYCLES(FC)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .thermalSenseInput(th), .lightLevelInput(lt), .lineSenseInput(ln),
    .supplyOnLevel(sOn), .supplyResetLevel(sRst), .supplyOvervoltageLevel(sOv),
    .gatePulseOutput(gate), .currentReference(cref), .valleyNumber(vn),
    .highLineRange(hl), .faultLatched(fl), .faultTimerRunning(ft), .lightLevelPullupEn(pu));
  lfv_ctrl #(.STEEP_FOLDBACK(1'b1), .LATCH_OVERTEMP(1'b1), .HOLD_CYCLES(HC),
    .FAULT_CYCLES(FC)) dutSteep (.ref_clk(ref_clk), .rst_n(rst_n),
    .thermalSenseInput(th), .lightLevelInput(lt), .lineSenseInput(ln),
    .supplyOnLevel(sOn), .supplyResetLevel(sRst), .supplyOvervoltageLevel(sOv),
    .gatePulseOutput(gate2), .currentReference(cref2), .valleyNumber(vn2),
    .highLineRange(), .faultLatched(fl2), .faultTimerRunning(), .lightLevelPullupEn());
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic drive(input logic [7:0] t, l, n, input logic o);
    @(posedge ref_clk);
    th <= t;
    ltSet <= l;
    ln <= n;
    ltOpen <= o;
    waitc(12);
  endtask
  task automatic end_of_test();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    waitc(3000);
    n_fail++;
    end_of_test();
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    waitc(1);
    check(8'(gate), 8'h00);
    check(8'(vn), 8'h01);
    check(8'(pu), 8'h01);
    @(posedge ref_clk);
    sOn <= 1'b1;
    waitc(HC);
    check(8'(gate), 8'h00);
    waitc(6);
    check(8'(gate), 8'h01);
    foreach (ROWS[i]) begin
      drive(ROWS[i].th, ROWS[i].lt, ROWS[i].ln, 1'b0);
      if (ROWS[i].r1 != 8'hFF) check(cref, ROWS[i].r1);
      if (ROWS[i].r2 != 8'hFF) check(cref2, ROWS[i].r2);
      check(8'(vn), 8'(ROWS[i].v1));
      check(8'(vn2), 8'(ROWS[i].v2));
      check(8'(hl), 8'(ROWS[i].hl));
      check(8'(gate), 8'(ROWS[i].gt));
    end
    drive(8'h7F, 8'hFF, 8'h80, 1'b0);
    save = cref;
    check(8'(save > 8'h80 && save < 8'hFE), 8'h01);
    drive(8'h7F, 8'h66, 8'h80, 1'b0);
    check(8'(cref < save && cref > 8'h00), 8'h01);
    save = cref;
    drive(8'h60, 8'h66, 8'h80, 1'b0);
    check(8'(cref < save && cref > 8'h00), 8'h01);
    drive(8'h60, 8'h00, 8'h80, 1'b1);
    check(cref, 8'h80);
    drive(8'h40, 8'hFF, 8'h80, 1'b0);
    check(8'(ft), 8'h01);
    check(8'(fl), 8'h00);
    check(8'(fl2), 8'h01);
    drive(8'h50, 8'hFF, 8'h80, 1'b0);
    waitc(FC);
    check(8'(gate), 8'h00);
    drive(8'h60, 8'hFF, 8'h80, 1'b0);
    check(8'(gate), 8'h01);
    check(8'(fl2), 8'h01);
    @(posedge ref_clk);
    sOn <= 1'b0;
    sRst <= 1'b1;
    waitc(6);
    check(8'(fl2), 8'h00);
    @(posedge ref_clk);
    sRst <= 1'b0;
    sOn <= 1'b1;
    waitc(HC + 8);
    check(8'(gate2), 8'h01);
    drive(8'h90, 8'hFF, 8'h80, 1'b0);
    check(8'(ft), 8'h01);
    check(8'(fl2), 8'h00);
    drive(8'h60, 8'hFF, 8'h80, 1'b0);
    waitc(FC + HC);
    check(8'(gate), 8'h01);
    @(posedge ref_clk);
    sOv <= 1'b1;
    waitc(6);
    check(8'(ft), 8'h01);
    @(posedge ref_clk);
    sOv <= 1'b0;
    sOn <= 1'b0;
    waitc(FC + 8);
    check(8'(gate), 8'h00);
    @(posedge ref_clk);
    sOn <= 1'b1;
    waitc(HC + 8);
    check(8'(gate), 8'h01);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    waitc(5);
    check(8'(gate), 8'h00);
    check(cref, 8'h00);
    end_of_test();
  end
endmodule // led_foldback_dimming_valley_ctrl_tb_top

//--- test/lfv_ctrl_assertions.sv
// port assertions of the control block
`timescale 1ns/1ps
`include "lfv_params.svh"
module lfv_ctrl_assertions #(
  parameter bit STEEP_FOLDBACK = 1'b0,
  parameter int FAULT_CYCLES   = 20
) (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic [7:0] thermalSenseInput,
  input wire logic [7:0] lightLevelInput,
  input wire logic [7:0] lineSenseInput,
  input wire logic       supplyResetLevel,
  input wire logic       supplyOnLevel,
  input wire logic       supplyOvervoltageLevel,
  input wire logic       gatePulseOutput,
  input wire logic [7:0] currentReference,
  input wire logic       highLineRange,
  input wire logic       faultLatched,
  input wire logic       faultTimerRunning,
  input wire logic       lightLevelPullupEn
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // floor*255/256 rounds back to the floor code itself
  localparam logic [7:0] FLOOR = STEEP_FOLDBACK ? `LFV_FLOOR_QUARTER : `LFV_FLOOR_HALF;
  logic [31:0] waitCnt;
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !faultTimerRunning) waitCnt <= 32'h0;
    else waitCnt <= waitCnt + 32'h1;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence sDark; (lightLevelInput < `LFV_DIM_EN)[*5]; endsequence
  sequence sFloor;
    (thermalSenseInput <= `LFV_TF_STOP && thermalSenseInput >= `LFV_OTP_TRIP
     && lightLevelInput >= `LFV_DIM_FULL && gatePulseOutput)[*5];
  endsequence
  a_dark_no_gate: assert property (sDark |-> !gatePulseOutput)
    else $error("gate on while light level dark");
  a_dark_zero_ref: assert property (sDark |-> currentReference == 8'h00)
    else $error("reference not zero while dark");
  a_floor_level: assert property (sFloor |-> currentReference == FLOOR)
    else $error("foldback floor wrong");
  a_hold_off: assert property ($rose(supplyOnLevel) |-> !gatePulseOutput [*8])
    else $error("gate before hold-off");
  a_timer_gate: assert property (faultTimerRunning |-> !gatePulseOutput)
    else $error("gate during fault wait");
  a_latch_gate: assert property (faultLatched |-> !gatePulseOutput)
    else $error("gate while latched");
  a_latch_holds: assert property ((faultLatched && !supplyResetLevel)[*4] |=> faultLatched)
    else $error("latch cleared without supply reset");
  a_sd_ovp: assert property (gatePulseOutput && thermalSenseInput >= `LFV_SD_OVP
    |-> ##[1:5] faultTimerRunning)
    else $error("thermal overvoltage not handled");
  a_otp_trip: assert property (gatePulseOutput && thermalSenseInput < `LFV_OTP_TRIP
    |-> ##[1:5] (faultTimerRunning || faultLatched))
    else $error("overtemp not handled");
  a_supply_overvoltage_level: assert property (gatePulseOutput && supplyOvervoltageLevel
    |-> ##[1:5] faultTimerRunning)
    else $error("supply overvoltage not handled");
  a_line_high: assert property ((lineSenseInput > `LFV_LINE_HIGH)[*5] |-> highLineRange)
    else $error("high line not entered");
  a_line_low: assert property ((lineSenseInput < `LFV_LINE_LOW)[*5] |-> !highLineRange)
    else $error("low line not entered");
  a_pullup_on: assert property (lightLevelPullupEn)
    else $error("pull-up off");
  a_wait_length: assert property ($fell(faultTimerRunning) |-> waitCnt >= FAULT_CYCLES)
    else $error("fault wait too short");
endmodule // lfv_ctrl_assertions

bind lfv_ctrl lfv_ctrl_assertions #(.STEEP_FOLDBACK(STEEP_FOLDBACK),
  .FAULT_CYCLES(FAULT_CYCLES)) chk (.ref_clk, .rst_n, .thermalSenseInput,
  .lightLevelInput, .lineSenseInput, .supplyResetLevel, .supplyOnLevel,
  .supplyOvervoltageLevel, .gatePulseOutput, .currentReference, .highLineRange,
  .faultLatched, .faultTimerRunning, .lightLevelPullupEn);

//--- test/lfv_stage_model.sv
// far side model: light level pin of the sensing network
`timescale 1ns/1ps
module lfv_stage_model (
  input  wire logic [7:0] lightSet,
  input  wire logic       lightOpen,
  input  wire logic       pullupEn,
  output logic      [7:0] lightLevel
);
  // an open pin reaches the rail only through the pull-up, else it reads the inverted set level
  assign lightLevel = lightOpen ? (pullupEn ? 8'hFF : ~lightSet) : lightSet;
endmodule // lfv_stage_model
